/* rtl/pkc_top.sv */
// Protection key check during translation, with key cache, region selectors and two TLBs
`timescale 1ns/1ps
`default_nettype none
`include "pkc_regs.svh"
module pkc_top #(
    parameter int NKEY = `PKC_NKEY,
    parameter int NPIN = `PKC_NPIN,
    parameter int NSET = `PKC_NSET,
    parameter int NWAY = `PKC_NWAY
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // Key check enable from processor status
    input wire logic key_check_enable,
    // Key domain register move port
    input wire logic kdr_wr_en,
    input wire logic [$clog2(NKEY)-1:0] kdr_wr_idx,
    input wire logic [63:0] kdr_wr_data,
    input wire logic [$clog2(NKEY)-1:0] kdr_rd_idx,
    output logic [63:0] kdr_rd_data,
    // Region register move port
    input wire logic rr_wr_en,
    input wire logic [2:0] rr_wr_idx,
    input wire logic [`PKC_RID_W-1:0] rr_wr_data,
    // Instruction fetch translation
    input wire logic ifetch_valid,
    input wire logic [63:0] ifetch_va,
    output logic ifetch_resp_valid,
    output pkc_pkg::pkc_res_t ifetch_res,
    output logic [`PKC_PPN_W-1:0] ifetch_ppn,
    // Data and register stack engine translation
    input wire logic dacc_valid,
    output logic dacc_ready,
    input wire logic [63:0] dacc_va,
    input wire logic dacc_write,
    output logic dacc_resp_valid,
    output pkc_pkg::pkc_res_t dacc_res,
    output logic [`PKC_PPN_W-1:0] dacc_ppn,
    // TLB management operations
    input wire logic op_valid,
    input wire pkc_pkg::pkc_op_t op_code,
    input wire logic [63:0] op_va,
    input wire logic [$clog2(NPIN)-1:0] op_slot,
    input wire logic [`PKC_PPN_W-1:0] op_ppn,
    input wire logic [2:0] op_ar,
    input wire logic [`PKC_KEY_W-1:0] op_key,
    output logic op_done,
    output logic op_key_hit,
    output logic [`PKC_KEY_W-1:0] op_key_out
);
    localparam int IW = $clog2(NKEY);

    logic [63:0] kdr_reg [NKEY];
    logic [`PKC_RID_W-1:0] rr_reg [`PKC_NREGION];
    logic [63:0] kdr_rd_data_reg;
    logic ifetch_resp_valid_reg;
    pkc_pkg::pkc_res_t ifetch_res_reg;
    logic [`PKC_PPN_W-1:0] ifetch_ppn_reg;
    logic dacc_resp_valid_reg;
    pkc_pkg::pkc_res_t dacc_res_reg;
    logic [`PKC_PPN_W-1:0] dacc_ppn_reg;
    logic op_done_reg;
    logic op_key_hit_reg;
    logic [`PKC_KEY_W-1:0] op_key_out_reg;

    logic key_read;
    logic i_hit;
    logic d_hit;
    pkc_pkg::pkc_tlbe_t i_entry;
    pkc_pkg::pkc_tlbe_t d_entry;
    logic [`PKC_RID_W-1:0] d_sid;
    logic [`PKC_VPN_W-1:0] d_vpn;
    pkc_pkg::pkc_tlbe_t m_entry;
    pkc_pkg::pkc_kmatch_t i_km;
    pkc_pkg::pkc_kmatch_t d_km;
    pkc_pkg::pkc_acc_t d_acc;
    logic [`PKC_KEY_W-1:0] wr_key;
    logic [`PKC_KEY_W-1:0] d_key;

    // Key field of a key domain register image
    function automatic logic [`PKC_KEY_W-1:0] kdr_key(input logic [63:0] r);
        return r[`PKC_KDR_KEY_LSB +: `PKC_KEY_W];
    endfunction : kdr_key

    // Space identifier from the region selector bits of an address
    function automatic logic [`PKC_RID_W-1:0] sid_of(input logic [63:0] va);
        return rr_reg[va[`PKC_VRN_MSB:`PKC_VRN_LSB]];
    endfunction : sid_of

    function automatic logic [`PKC_VPN_W-1:0] vpn_of(input logic [63:0] va);
        return va[`PKC_VPN_MSB:`PKC_VPN_LSB];
    endfunction : vpn_of

    // Compare against every valid entry; lowest index wins on duplicates
    function automatic pkc_pkg::pkc_kmatch_t kc_match(input logic [`PKC_KEY_W-1:0] key);
        pkc_pkg::pkc_kmatch_t m;
        m = '0;
        for (int i = NKEY - 1; i >= 0; i--) begin
            if (kdr_reg[i][`PKC_KDR_V_BIT] && kdr_key(kdr_reg[i]) == key) begin
                m.found = 1'b1;
                m.wd = kdr_reg[i][`PKC_KDR_WD_BIT];
                m.rd = kdr_reg[i][`PKC_KDR_RD_BIT];
                m.xd = kdr_reg[i][`PKC_KDR_XD_BIT];
            end
        end
        return m;
    endfunction : kc_match

    // Outcome of one reference; no address space model input exists
    function automatic pkc_pkg::pkc_res_t resolve(input logic en,
                                                  input logic hit,
                                                  input logic [2:0] ar,
                                                  input pkc_pkg::pkc_kmatch_t km,
                                                  input pkc_pkg::pkc_acc_t acc);
        logic kdeny;
        logic ar_ok;
        kdeny = 1'b0;
        ar_ok = 1'b0;
        unique case (acc)
            pkc_pkg::ACC_FETCH: begin
                kdeny = km.xd;
                ar_ok = ar[`PKC_AR_X_BIT];
            end
            pkc_pkg::ACC_READ: begin
                kdeny = km.rd;
                ar_ok = ar[`PKC_AR_R_BIT];
            end
            pkc_pkg::ACC_WRITE: begin
                kdeny = km.wd;
                ar_ok = ar[`PKC_AR_W_BIT];
            end
        endcase
        if (!hit) begin
            return pkc_pkg::RES_TLB_MISS;
        end else if (en && !km.found) begin
            return pkc_pkg::RES_KEY_MISS;
        end else if (en && kdeny) begin
            return pkc_pkg::RES_KEY_PERM;
        end else if (!ar_ok) begin
            return pkc_pkg::RES_AR_FAULT;
        end
        return pkc_pkg::RES_OK; // Key faults need en set
    endfunction : resolve

    // Key domain registers; an invalidating write also clears any copy of its key
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < NKEY; i++) kdr_reg[i] <= `PKC_KDR_RESET;
        end else if (ce && kdr_wr_en) begin
            for (int i = 0; i < NKEY; i++) begin
                if (kdr_wr_idx == IW'(i)) begin
                    kdr_reg[i] <= kdr_wr_data & `PKC_KDR_MASK;
                end else if (!kdr_wr_data[`PKC_KDR_V_BIT]
                             && kdr_key(kdr_reg[i]) == wr_key) begin
                    kdr_reg[i][`PKC_KDR_V_BIT] <= 1'b0;
                end
            end
        end
    end

    // Register readback, one cycle after the index is given
    always_ff @(posedge mclk) begin
        if (srst) begin
            kdr_rd_data_reg <= '0;
        end else if (ce) begin
            kdr_rd_data_reg <= kdr_reg[kdr_rd_idx];
        end
    end

    // Region registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < `PKC_NREGION; i++) rr_reg[i] <= '0;
        end else if (ce && rr_wr_en) begin
            rr_reg[rr_wr_idx] <= rr_wr_data;
        end
    end

    // Key read borrows the data lookup, so data traffic stalls for that cycle
    assign key_read = op_valid && op_code == pkc_pkg::OP_KEY_READ;
    assign dacc_ready = !key_read;
    assign d_sid = key_read ? sid_of(op_va) : sid_of(dacc_va);
    assign d_vpn = key_read ? vpn_of(op_va) : vpn_of(dacc_va);
    assign d_key = d_entry.key;
    assign wr_key = kdr_key(kdr_wr_data);
    assign d_acc = dacc_write ? pkc_pkg::ACC_WRITE : pkc_pkg::ACC_READ;
    assign i_km = kc_match(i_entry.key);
    assign d_km = kc_match(d_entry.key);

    // Entry image for inserts and tag for purges
    assign m_entry = '{v: 1'b1, sid: sid_of(op_va), virtual_page_number: vpn_of(op_va),
                       ppn: op_ppn, ar: op_ar, key: op_key};

    // Instruction buffer; eight pinned slots, set associative cache
    pkc_tlb #(.NPIN(NPIN), .NSET(NSET), .NWAY(NWAY)) u_itlb (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .lk_sid(sid_of(ifetch_va)),
        .lk_vpn(vpn_of(ifetch_va)),
        .lk_hit(i_hit),
        .lk_entry(i_entry),
        .ins_pin(op_valid && op_code == pkc_pkg::OP_INS_PIN_I),
        .ins_cache(op_valid && op_code == pkc_pkg::OP_INS_CACHE_I),
        .purge_pin(op_valid && op_code == pkc_pkg::OP_PURGE_PIN_I),
        .purge_cache(op_valid && op_code == pkc_pkg::OP_PURGE_CACHE),
        .m_slot(op_slot),
        .m_entry(m_entry)
    );

    // Data buffer; the cached purge strobe is shared with the instruction side
    pkc_tlb #(.NPIN(NPIN), .NSET(NSET), .NWAY(NWAY)) u_dtlb (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .lk_sid(d_sid),
        .lk_vpn(d_vpn),
        .lk_hit(d_hit),
        .lk_entry(d_entry),
        .ins_pin(op_valid && op_code == pkc_pkg::OP_INS_PIN_D),
        .ins_cache(op_valid && op_code == pkc_pkg::OP_INS_CACHE_D),
        .purge_pin(op_valid && op_code == pkc_pkg::OP_PURGE_PIN_D),
        .purge_cache(op_valid && op_code == pkc_pkg::OP_PURGE_CACHE),
        .m_slot(op_slot),
        .m_entry(m_entry)
    );

    // Fetch result, registered so the check sits inside translation timing
    always_ff @(posedge mclk) begin
        if (srst) begin
            ifetch_resp_valid_reg <= 1'b0;
            ifetch_res_reg <= pkc_pkg::RES_OK;
            ifetch_ppn_reg <= '0;
        end else if (ce) begin
            ifetch_resp_valid_reg <= ifetch_valid;
            ifetch_res_reg <= resolve(key_check_enable, i_hit, i_entry.ar, i_km,
                                      pkc_pkg::ACC_FETCH);
            ifetch_ppn_reg <= i_hit ? i_entry.ppn : '0;
        end
    end

    // Data and stack engine result
    always_ff @(posedge mclk) begin
        if (srst) begin
            dacc_resp_valid_reg <= 1'b0;
            dacc_res_reg <= pkc_pkg::RES_OK;
            dacc_ppn_reg <= '0;
        end else if (ce) begin
            dacc_resp_valid_reg <= dacc_valid && dacc_ready;
            dacc_res_reg <= resolve(key_check_enable, d_hit, d_entry.ar, d_km, d_acc);
            dacc_ppn_reg <= d_hit ? d_entry.ppn : '0;
        end
    end

    // Operation completion and key read result, data side only
    always_ff @(posedge mclk) begin
        if (srst) begin
            op_done_reg <= 1'b0;
            op_key_hit_reg <= 1'b0;
            op_key_out_reg <= '0;
        end else if (ce) begin
            op_done_reg <= op_valid;
            if (key_read) begin
                op_key_hit_reg <= d_hit;
                op_key_out_reg <= d_hit ? d_key : '0;
            end
        end
    end

    assign kdr_rd_data = kdr_rd_data_reg;
    assign ifetch_resp_valid = ifetch_resp_valid_reg;
    assign ifetch_res = ifetch_res_reg;
    assign ifetch_ppn = ifetch_ppn_reg;
    assign dacc_resp_valid = dacc_resp_valid_reg;
    assign dacc_res = dacc_res_reg;
    assign dacc_ppn = dacc_ppn_reg;
    assign op_done = op_done_reg;
    assign op_key_hit = op_key_hit_reg;
    assign op_key_out = op_key_out_reg;

    // Checks on translation outcomes, key invalidation and key reads
    AST_KEY_OFF: assert property (@(posedge mclk) disable iff (srst)
        ce && !key_check_enable |=> ifetch_res != pkc_pkg::RES_KEY_MISS
            && ifetch_res != pkc_pkg::RES_KEY_PERM && dacc_res != pkc_pkg::RES_KEY_MISS
            && dacc_res != pkc_pkg::RES_KEY_PERM)
        else $error("key fault while checking is off");
    AST_FETCH_RESP: assert property (@(posedge mclk) disable iff (srst)
        ce && ifetch_valid |=> ifetch_resp_valid)
        else $error("fetch not answered");
    AST_WD: assert property (@(posedge mclk) disable iff (srst)
        ce && dacc_valid && dacc_ready && dacc_write && key_check_enable && d_hit
            && d_km.found && d_km.wd |=> dacc_res == pkc_pkg::RES_KEY_PERM)
        else $error("write allowed under write disable");
    AST_RD: assert property (@(posedge mclk) disable iff (srst)
        ce && dacc_valid && dacc_ready && !dacc_write && key_check_enable && d_hit
            && d_km.found && d_km.rd |=> dacc_res == pkc_pkg::RES_KEY_PERM)
        else $error("read allowed under read disable");
    AST_XD: assert property (@(posedge mclk) disable iff (srst)
        ce && ifetch_valid && key_check_enable && i_hit && i_km.found && i_km.xd
            |=> ifetch_res == pkc_pkg::RES_KEY_PERM)
        else $error("fetch allowed under execute disable");
    AST_KEY_MISS: assert property (@(posedge mclk) disable iff (srst)
        ce && ifetch_valid && key_check_enable && i_hit && !i_km.found
            |=> ifetch_res == pkc_pkg::RES_KEY_MISS)
        else $error("missing key not reported");
    AST_TLB_MISS: assert property (@(posedge mclk) disable iff (srst)
        ce && ifetch_valid && !i_hit |=> ifetch_res == pkc_pkg::RES_TLB_MISS && ifetch_ppn == '0)
        else $error("fetch miss not reported");
    AST_PURGE: assert property (@(posedge mclk) disable iff (srst)
        ce && kdr_wr_en && !kdr_wr_data[`PKC_KDR_V_BIT] |=> !kc_match($past(wr_key)).found)
        else $error("invalidated key still matches");
    AST_KEY_READ: assert property (@(posedge mclk) disable iff (srst)
        ce && key_read && d_hit |=> op_done && op_key_hit && op_key_out == $past(d_key))
        else $error("key read returned wrong key");
endmodule : pkc_top
`default_nettype wire

/* rtl/pkc_regs.svh */
// Field positions, widths and timing counts of the protection key checker
`ifndef PKC_REGS_SVH
`define PKC_REGS_SVH
`define PKC_KDR_V_BIT 0
`define PKC_KDR_WD_BIT 1
`define PKC_KDR_RD_BIT 2
`define PKC_KDR_XD_BIT 3
`define PKC_KDR_KEY_LSB 8
`define PKC_KEY_W 24
`define PKC_KDR_MASK 64'h00000000ffffff0f
`define PKC_KDR_RESET 64'h0000000000000000
`define PKC_NKEY 16
`define PKC_VRN_MSB 63
`define PKC_VRN_LSB 61
`define PKC_NREGION 8
`define PKC_VPN_MSB 60
`define PKC_VPN_LSB 12
`define PKC_VPN_W 49
`define PKC_RID_W 24
`define PKC_PPN_W 38
`define PKC_AR_R_BIT 0
`define PKC_AR_W_BIT 1
`define PKC_AR_X_BIT 2
`define PKC_NPIN 8
`define PKC_NSET 4
`define PKC_NWAY 2
`define PKC_RESP_LAT 1
`endif

/* rtl/pkc_pkg.sv */
// Types shared by the protection key checker and its translation buffers
`include "pkc_regs.svh"
package pkc_pkg;
    typedef enum logic [2:0] {
        OP_INS_PIN_I, OP_INS_PIN_D, OP_INS_CACHE_I, OP_INS_CACHE_D,
        OP_PURGE_PIN_I, OP_PURGE_PIN_D, OP_PURGE_CACHE, OP_KEY_READ
    } pkc_op_t;
    typedef enum logic [1:0] {ACC_FETCH, ACC_READ, ACC_WRITE} pkc_acc_t;
    typedef enum logic [2:0] {
        RES_OK, RES_TLB_MISS, RES_KEY_MISS, RES_KEY_PERM, RES_AR_FAULT
    } pkc_res_t;
    typedef struct packed {
        logic v;
        logic [`PKC_RID_W-1:0] sid;
        logic [`PKC_VPN_W-1:0] virtual_page_number;
        logic [`PKC_PPN_W-1:0] ppn;
        logic [2:0] ar;
        logic [`PKC_KEY_W-1:0] key;
    } pkc_tlbe_t;
    typedef struct packed {
        logic found;
        logic wd;
        logic rd;
        logic xd;
    } pkc_kmatch_t;
endpackage : pkc_pkg

/* rtl/pkc_tlb.sv */
// One translation buffer: software-slotted pinned entries plus a set associative cache
`timescale 1ns/1ps
`default_nettype none
`include "pkc_regs.svh"
module pkc_tlb #(
    parameter int NPIN = `PKC_NPIN,
    parameter int NSET = `PKC_NSET,
    parameter int NWAY = `PKC_NWAY
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // Lookup
    input wire logic [`PKC_RID_W-1:0] lk_sid,
    input wire logic [`PKC_VPN_W-1:0] lk_vpn,
    output logic lk_hit,
    output pkc_pkg::pkc_tlbe_t lk_entry,
    // Management strobes
    input wire logic ins_pin,
    input wire logic ins_cache,
    input wire logic purge_pin,
    input wire logic purge_cache,
    input wire logic [$clog2(NPIN)-1:0] m_slot,
    input wire pkc_pkg::pkc_tlbe_t m_entry
);
    localparam int PW = $clog2(NPIN);
    localparam int SW = $clog2(NSET);
    localparam int WW = $clog2(NWAY);

    pkc_pkg::pkc_tlbe_t pin_reg [NPIN];
    pkc_pkg::pkc_tlbe_t cache_reg [NSET][NWAY];
    logic [WW-1:0] rr_ptr_reg [NSET];
    logic [WW-1:0] victim;
    logic [SW-1:0] ms;
    logic [SW-1:0] ls;

    function automatic logic tag_eq(input pkc_pkg::pkc_tlbe_t e,
                                    input logic [`PKC_RID_W-1:0] sid,
                                    input logic [`PKC_VPN_W-1:0] virtual_page_number);
        return e.v && e.sid == sid && e.virtual_page_number == virtual_page_number;
    endfunction : tag_eq

    assign ms = m_entry.virtual_page_number[SW-1:0];
    assign ls = lk_vpn[SW-1:0];

    // Pinned slots change only by software insert or purge, never by replacement
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < NPIN; i++) pin_reg[i] <= '0;
        end else if (ce) begin
            for (int i = 0; i < NPIN; i++) begin
                if (ins_pin && m_slot == PW'(i)) begin
                    pin_reg[i] <= m_entry;
                end else if (purge_pin && tag_eq(pin_reg[i], m_entry.sid, m_entry.virtual_page_number)) begin
                    pin_reg[i].v <= 1'b0; // Purge matches by tag, not by slot
                end
            end
        end
    end

    // Way choice: a matching way first, then a free one, then round robin
    always_comb begin
        victim = rr_ptr_reg[ms];
        for (int w = NWAY - 1; w >= 0; w--) begin
            if (!cache_reg[ms][w].v) victim = WW'(w);
        end
        for (int w = NWAY - 1; w >= 0; w--) begin
            if (tag_eq(cache_reg[ms][w], m_entry.sid, m_entry.virtual_page_number)) victim = WW'(w);
        end
    end

    // Cached entries; any insert drops an older copy of the same tag
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int s = 0; s < NSET; s++) begin
                rr_ptr_reg[s] <= '0;
                for (int w = 0; w < NWAY; w++) cache_reg[s][w] <= '0;
            end
        end else if (ce) begin
            for (int s = 0; s < NSET; s++) begin
                for (int w = 0; w < NWAY; w++) begin
                    if (ins_cache && ms == SW'(s) && victim == WW'(w)) begin
                        cache_reg[s][w] <= m_entry;
                    end else if ((purge_cache || ins_pin || ins_cache)
                                 && tag_eq(cache_reg[s][w], m_entry.sid, m_entry.virtual_page_number)) begin
                        cache_reg[s][w].v <= 1'b0;
                    end
                end
            end
            if (ins_cache) rr_ptr_reg[ms] <= WW'(victim + 1'b1);
        end
    end

    // Tag compare on space identifier and page number, pinned slots first
    always_comb begin
        lk_hit = 1'b0;
        lk_entry = '0;
        for (int i = 0; i < NPIN; i++) begin
            if (!lk_hit && tag_eq(pin_reg[i], lk_sid, lk_vpn)) begin
                lk_hit = 1'b1;
                lk_entry = pin_reg[i];
            end
        end
        for (int w = 0; w < NWAY; w++) begin
            if (!lk_hit && tag_eq(cache_reg[ls][w], lk_sid, lk_vpn)) begin
                lk_hit = 1'b1;
                lk_entry = cache_reg[ls][w];
            end
        end
    end
endmodule : pkc_tlb
`default_nettype wire

/* testbench/pkc_pipe_model.sv */
// Pipeline model: offers one fetch or data reference for each go pulse
`timescale 1ns/1ps
`default_nettype none
module pkc_pipe_model (
    // Clock and tester request
    input wire logic mclk,
    input wire logic go,
    input wire logic is_fetch,
    input wire logic is_write,
    input wire logic [63:0] va,
    // Translation request ports
    output logic ifetch_valid = 1'b0,
    output logic [63:0] ifetch_va = 64'h0,
    output logic dacc_valid = 1'b0,
    output logic [63:0] dacc_va = 64'h0,
    output logic dacc_write = 1'b0,
    input wire logic dacc_ready
);
    // Fetch, data and stack traffic all go out for the key
    always @(posedge mclk) begin
        if (go) begin
            ifetch_valid <= is_fetch;
            dacc_valid <= !is_fetch;
            ifetch_va <= va;
            dacc_va <= va;
            dacc_write <= is_write;
        end else if (!dacc_valid || dacc_ready) begin
            // Released lines toggle so a stale address is never reused
            ifetch_valid <= 1'b0;
            dacc_valid <= 1'b0;
            ifetch_va <= ~ifetch_va;
            dacc_va <= ~dacc_va;
            dacc_write <= ~dacc_write;
        end
    end
endmodule : pkc_pipe_model
`default_nettype wire

/* testbench/tb_protection_key_checker_tlb_org.sv */
// Self-checking bench for key checks, key cache purges and TLB operations
`timescale 1ns/1ps
`default_nettype none
module tb_protection_key_checker_tlb_org;
    typedef struct packed {
        logic kce;
        logic f;
        logic w;
        logic [7:0] virtual_page_number;
        pkc_pkg::pkc_res_t res;
    } pkc_row_t;
    logic mclk = 1'b0, srst = 1'b1, kce = 1'b0, go = 1'b0, f = 1'b0, w = 1'b0, ce = 1'b1;
    logic kdr_wr_en = 1'b0, rr_wr_en = 1'b0, op_valid = 1'b0;
    logic [3:0] kdr_wr_idx = 4'h0;
    logic [63:0] kdr_wr_data = 64'h0, va = 64'h0, op_va = 64'h0;
    logic [2:0] op_slot = 3'h0, op_ar = 3'h0;
    logic [37:0] op_ppn = 38'h0;
    logic [23:0] op_key = 24'h0;
    pkc_pkg::pkc_op_t op_code = pkc_pkg::OP_KEY_READ;
    wire logic ifetch_valid, dacc_valid, dacc_write, dacc_ready, op_done, op_key_hit;
    wire logic ifetch_resp_valid, dacc_resp_valid;
    wire logic [63:0] ifetch_va, dacc_va, kdr_rd_data;
    wire logic [23:0] op_key_out;
    wire logic [37:0] ifetch_ppn, dacc_ppn;
    pkc_pkg::pkc_res_t ifetch_res, dacc_res;
    int fail_count = 0, samples_checked = 0;
    // Keys: a write-disabled, b execute-disabled, c read-disabled, d absent
    pkc_row_t rows [10] = '{
        '{1'b1, 1'b0, 1'b0, 8'h01, pkc_pkg::RES_OK},
        '{1'b1, 1'b0, 1'b1, 8'h01, pkc_pkg::RES_KEY_PERM},
        '{1'b1, 1'b1, 1'b0, 8'h02, pkc_pkg::RES_KEY_PERM},
        '{1'b0, 1'b1, 1'b0, 8'h02, pkc_pkg::RES_OK},
        '{1'b1, 1'b0, 1'b0, 8'h09, pkc_pkg::RES_TLB_MISS},
        '{1'b1, 1'b0, 1'b1, 8'h03, pkc_pkg::RES_AR_FAULT},
        '{1'b1, 1'b0, 1'b0, 8'h03, pkc_pkg::RES_OK},
        '{1'b1, 1'b0, 1'b0, 8'h04, pkc_pkg::RES_KEY_PERM},
        '{1'b1, 1'b0, 1'b1, 8'h04, pkc_pkg::RES_OK},
        '{1'b1, 1'b0, 1'b0, 8'h05, pkc_pkg::RES_KEY_MISS}
    };
    always #2.5 mclk = ~mclk;
    pkc_pipe_model pipe (.mclk(mclk), .go(go), .is_fetch(f), .is_write(w), .va(va),
        .ifetch_valid(ifetch_valid), .ifetch_va(ifetch_va), .dacc_valid(dacc_valid),
        .dacc_va(dacc_va), .dacc_write(dacc_write), .dacc_ready(dacc_ready));
    pkc_top uut (.mclk(mclk), .srst(srst), .ce(ce), .key_check_enable(kce),
        .kdr_wr_en(kdr_wr_en), .kdr_wr_idx(kdr_wr_idx), .kdr_wr_data(kdr_wr_data),
        .kdr_rd_idx(4'h0), .kdr_rd_data(kdr_rd_data), .rr_wr_en(rr_wr_en),
        .rr_wr_idx(3'h0), .rr_wr_data(24'h000005), .ifetch_valid(ifetch_valid),
        .ifetch_va(ifetch_va), .ifetch_resp_valid(ifetch_resp_valid),
        .ifetch_res(ifetch_res), .ifetch_ppn(ifetch_ppn), .dacc_valid(dacc_valid),
        .dacc_ready(dacc_ready), .dacc_va(dacc_va), .dacc_write(dacc_write),
        .dacc_resp_valid(dacc_resp_valid), .dacc_res(dacc_res), .dacc_ppn(dacc_ppn),
        .op_valid(op_valid), .op_code(op_code), .op_va(op_va), .op_slot(op_slot),
        .op_ppn(op_ppn), .op_ar(op_ar), .op_key(op_key), .op_done(op_done),
        .op_key_hit(op_key_hit), .op_key_out(op_key_out));
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One reference through the pipeline model, result one edge after it is taken
    task automatic acc(input logic k, input logic fe, input logic wr, input logic [7:0] virtual_page_number,
                       input pkc_pkg::pkc_res_t exp);
        kce = k;
        f = fe;
        w = wr;
        va = {44'h0, virtual_page_number, 12'h000};
        go = 1'b1;
        @(negedge mclk);
        go = 1'b0;
        @(negedge mclk);
        chk("resp_valid", 64'h1, fe ? ifetch_resp_valid : dacc_resp_valid);
        chk("res", exp, fe ? ifetch_res : dacc_res);
        chk("ppn", (exp == pkc_pkg::RES_TLB_MISS) ? 64'h0 : {56'h0, virtual_page_number},
            fe ? ifetch_ppn : dacc_ppn);
    endtask : acc
    task automatic kw(input logic [3:0] idx, input logic [63:0] d);
        kdr_wr_en = 1'b1;
        kdr_wr_idx = idx;
        kdr_wr_data = d;
        @(negedge mclk);
        kdr_wr_en = 1'b0;
        @(negedge mclk);
    endtask : kw
    task automatic do_op(input pkc_pkg::pkc_op_t c, input logic [7:0] virtual_page_number,
                         input logic [2:0] sl, input logic [2:0] ar, input logic [23:0] k);
        op_valid = 1'b1;
        op_code = c;
        op_va = {44'h0, virtual_page_number, 12'h000};
        op_slot = sl;
        op_ar = ar;
        op_key = k;
        op_ppn = {30'h0, virtual_page_number};
        @(negedge mclk);
        op_valid = 1'b0;
        chk("op_done", 64'h1, op_done);
        @(negedge mclk);
    endtask : do_op
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog at 1000 cycles, well beyond the roughly 70 cycles the sequence needs
    initial begin
        #5000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        chk("kdr_rd_data", 64'h0, kdr_rd_data);
        rr_wr_en = 1'b1;
        @(negedge mclk);
        rr_wr_en = 1'b0;
        // Bits outside the fields must read back as zero
        kw(4'h0, 64'hff00_0000_0a0a_0af3);
        @(negedge mclk);
        chk("kdr_rd_data", 64'h0a0a_0a03, kdr_rd_data);
        kw(4'h1, 64'h0b09);
        kw(4'h2, 64'h0c05);
        do_op(pkc_pkg::OP_INS_PIN_D, 8'h01, 3'h0, 3'h7, 24'h0a0a0a);
        do_op(pkc_pkg::OP_INS_PIN_I, 8'h02, 3'h1, 3'h7, 24'h00000b);
        do_op(pkc_pkg::OP_INS_PIN_D, 8'h05, 3'h7, 3'h7, 24'h00000d);
        do_op(pkc_pkg::OP_INS_CACHE_D, 8'h03, 3'h0, 3'h1, 24'h00000b);
        do_op(pkc_pkg::OP_INS_CACHE_D, 8'h04, 3'h0, 3'h7, 24'h00000c);
        for (int i = 0; i < 10; i++) begin
            acc(rows[i].kce, rows[i].f, rows[i].w, rows[i].virtual_page_number, rows[i].res);
        end
        do_op(pkc_pkg::OP_KEY_READ, 8'h01, 3'h0, 3'h0, 24'h0);
        chk("op_key_hit", 64'h1, op_key_hit);
        chk("op_key_out", 64'h0a0a0a, op_key_out);
        do_op(pkc_pkg::OP_KEY_READ, 8'h02, 3'h0, 3'h0, 24'h0);
        chk("op_key_hit", 64'h0, op_key_hit);
        // Same key with valid clear, then purges of each kind
        kw(4'h0, 64'h0a0a_0a00);
        acc(1'b1, 1'b0, 1'b0, 8'h01, pkc_pkg::RES_KEY_MISS);
        do_op(pkc_pkg::OP_PURGE_PIN_I, 8'h01, 3'h0, 3'h0, 24'h0);
        acc(1'b1, 1'b0, 1'b0, 8'h01, pkc_pkg::RES_KEY_MISS);
        do_op(pkc_pkg::OP_PURGE_PIN_D, 8'h01, 3'h0, 3'h0, 24'h0);
        acc(1'b1, 1'b0, 1'b0, 8'h01, pkc_pkg::RES_TLB_MISS);
        do_op(pkc_pkg::OP_PURGE_CACHE, 8'h03, 3'h0, 3'h0, 24'h0);
        acc(1'b1, 1'b0, 1'b0, 8'h03, pkc_pkg::RES_TLB_MISS);
        // Same key invalidated through another index clears every copy
        kw(4'h3, 64'h0b08);
        acc(1'b1, 1'b1, 1'b0, 8'h02, pkc_pkg::RES_KEY_MISS);
        // Frozen while the enable is low: this write must not land
        ce = 1'b0;
        kw(4'h0, 64'h0a0a_0a01);
        ce = 1'b1;
        @(negedge mclk);
        chk("kdr_rd_data", 64'h0a0a_0a00, kdr_rd_data);
        // Mid-run reset empties the key cache and both buffers
        srst = 1'b1;
        @(negedge mclk);
        srst = 1'b0;
        @(negedge mclk);
        chk("kdr_rd_data", 64'h0, kdr_rd_data);
        acc(1'b1, 1'b1, 1'b0, 8'h02, pkc_pkg::RES_TLB_MISS);
        tally_and_finish();
    end
endmodule : tb_protection_key_checker_tlb_org
`default_nettype wire
